/* File: pcs_rx_decode_sync.sv */
// receive pcs: comma alignment, decoding, link sync, de-encapsulation, status
`timescale 1ns/1ps
`include "pcs_rx_defines.svh"

// **********************************************************************
// **********************************************************************

module pcs_rx_decode_sync (
    // clock and synchronous reset
    input wire logic mclk,
    input wire logic reset,
    // raw code groups from the serdes, on mclk
    input wire logic [9:0] tbiRxData,
    // operating mode and transmit activity
    input wire logic sgmiiMode,
    input wire logic autoNegEna,
    input wire logic halfDuplex,
    input wire logic txActive,
    // byte stream towards the mac
    output pcs_rx_pkg::gmiiRx_t gmiiRx,
    // mii status
    output logic miiRxCrs,
    output logic miiRxCol,
    // board indicators
    output logic ledLink,
    output logic ledPanelLink,
    output logic ledCrs,
    output logic ledCol
);

    // **********************************************************************
    // helpers
    // **********************************************************************

    // comma positions in the two-word window
    function automatic logic [9:0] commaMask(input logic [19:0] win);
        logic [9:0] m;
        m = '0;
        for (int i = 0; i < 10; i++)
        begin
            m[i] = (win[i +: 7] == `COMMA_NEG) || (win[i +: 7] == `COMMA_POS);
        end
        return m;
    endfunction

    // lowest offset wins so the pick is deterministic
    function automatic logic [3:0] firstSet(input logic [9:0] m);
        logic [3:0] idx;
        idx = '0;
        for (int i = 9; i >= 0; i--)
        begin
            if (m[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // match a control character decoded without a code error
    function automatic logic isCtl(input pcs_rx_pkg::decChar_t d, input logic [7:0] code);
        return d.valid && d.isK && !d.codeErr && (d.data == code);
    endfunction

    // **********************************************************************
    // alignment and decoding
    // **********************************************************************

    pcs_rx_pkg::rxMain_t st_r;
    pcs_rx_pkg::rxMain_t st_nxt;
    pcs_rx_pkg::decChar_t dec;
    logic [19:0] window;
    logic [9:0] commas;
    logic [3:0] alignOff;
    logic [9:0] aligned;
    logic search;
    logic realign;
    logic bad;
    logic errIn;
    logic isComma;
    logic rxActive;

    // newer word above, so bit order matches arrival order
    assign window = {tbiRxData, st_r.prevWord};
    assign commas = commaMask(window);
    assign search = (st_r.sync != pcs_rx_pkg::SYNC_OK);
    // boundary only moves while not synchronized
    assign alignOff = (search && |commas) ? firstSet(commas) : st_r.offset;
    assign realign = search && |commas && (alignOff != st_r.offset);
    assign aligned = window[alignOff +: 10];

    pcs_dec_8b10b u_dec (
        .mclk(mclk),
        .reset(reset),
        .charIn(aligned),
        .charEn(st_nxt.locked),
        .decOut(dec)
    );

    // error and comma classification of the decoded group
    assign bad = dec.valid && (dec.codeErr || dec.dispErr);
    assign errIn = bad || st_r.misplaced;
    assign isComma = isCtl(dec, `K_COMMA1) || isCtl(dec, `K_COMMA5) || isCtl(dec, `K_COMMA7);
    assign rxActive = (st_r.rx == pcs_rx_pkg::RX_FRAME) || (st_r.rx == pcs_rx_pkg::RX_END);

    // **********************************************************************
    // next state
    // **********************************************************************

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.prevWord = tbiRxData;
        // registered so it lines up with the decoder output
        st_nxt.misplaced = !search && |(commas & ~(10'h001 << st_r.offset));
        st_nxt.gmii = '0;
        st_nxt.lastK285 = isCtl(dec, `K_COMMA5);
        st_nxt.idleSeen = st_r.lastK285 && dec.valid && !dec.isK && !bad;

        // link synchronization
        case (st_r.sync)
            pcs_rx_pkg::SYNC_LOSS:
            begin
                if (isComma && !bad)
                begin
                    st_nxt.sync = pcs_rx_pkg::SYNC_ACQ;
                    st_nxt.commaCnt = 2'h1;
                end
            end
            pcs_rx_pkg::SYNC_ACQ:
            begin
                if (bad)
                begin
                    st_nxt.sync = pcs_rx_pkg::SYNC_LOSS;
                    st_nxt.commaCnt = '0;
                end
                else if (isComma)
                begin
                    st_nxt.commaCnt = st_r.commaCnt + 2'h1;
                    if (st_r.commaCnt + 2'h1 == `SYNC_COMMAS)
                    begin
                        st_nxt.sync = pcs_rx_pkg::SYNC_OK;
                        st_nxt.errCnt = '0;
                        st_nxt.goodCnt = '0;
                    end
                end
            end
            pcs_rx_pkg::SYNC_OK:
            begin
                if (errIn)
                begin
                    st_nxt.goodCnt = '0;
                    st_nxt.errCnt = st_r.errCnt + 3'h1;
                    if (st_r.errCnt + 3'h1 == `ERR_LIMIT)
                    begin
                        st_nxt.sync = pcs_rx_pkg::SYNC_LOSS;
                        st_nxt.errCnt = '0;
                        st_nxt.commaCnt = '0;
                        st_nxt.locked = 1'b0;
                    end
                end
                else if (dec.valid)
                begin
                    st_nxt.goodCnt = st_r.goodCnt + 3'h1;
                    if (st_r.goodCnt + 3'h1 == `GOOD_RUN)
                    begin
                        st_nxt.goodCnt = '0;
                        if (st_r.errCnt != 3'h0)
                        begin
                            st_nxt.errCnt = st_r.errCnt - 3'h1;
                        end
                    end
                end
            end
            default:
            begin
                st_nxt.sync = pcs_rx_pkg::SYNC_LOSS;
            end
        endcase

        // comma search; a moved boundary restarts acquisition
        if (search && |commas)
        begin
            st_nxt.locked = 1'b1;
            st_nxt.offset = alignOff;
        end
        if (realign)
        begin
            st_nxt.sync = pcs_rx_pkg::SYNC_LOSS;
            st_nxt.commaCnt = '0;
        end

        // frame de-encapsulation, only on a synchronized stream
        if (search)
        begin
            st_nxt.rx = pcs_rx_pkg::RX_IDLE;
        end
        else
        begin
            case (st_r.rx)
                pcs_rx_pkg::RX_IDLE:
                begin
                    if (!bad && (isCtl(dec, `K_COMMA5) || st_nxt.idleSeen))
                    begin
                        st_nxt.rx = pcs_rx_pkg::RX_IDLE;
                    end
                    else if (!bad && st_r.idleSeen && isCtl(dec, `K_SOF))
                    begin
                        st_nxt.rx = pcs_rx_pkg::RX_FRAME;
                        st_nxt.gmii.dv = 1'b1;
                        st_nxt.gmii.data = `PREAMBLE;
                    end
                    else
                    begin
                        st_nxt.rx = pcs_rx_pkg::RX_FALSE;
                        st_nxt.gmii.er = 1'b1;
                        st_nxt.gmii.data = `FALSE_CARR;
                    end
                end
                pcs_rx_pkg::RX_FALSE:
                begin
                    // held until the next idle comma
                    if (isCtl(dec, `K_COMMA5) && !bad)
                    begin
                        st_nxt.rx = pcs_rx_pkg::RX_IDLE;
                    end
                    else
                    begin
                        st_nxt.gmii.er = 1'b1;
                        st_nxt.gmii.data = `FALSE_CARR;
                    end
                end
                pcs_rx_pkg::RX_FRAME:
                begin
                    if (isCtl(dec, `K_EOF) && !bad)
                    begin
                        st_nxt.rx = pcs_rx_pkg::RX_END;
                    end
                    else if (isCtl(dec, `K_COMMA5) && !bad)
                    begin
                        // idle without /T/: cut the frame with an error
                        st_nxt.rx = pcs_rx_pkg::RX_IDLE;
                        st_nxt.gmii.dv = 1'b1;
                        st_nxt.gmii.er = 1'b1;
                    end
                    else if (bad || (dec.isK && !isCtl(dec, `K_ERRP)))
                    begin
                        st_nxt.gmii.dv = 1'b1;
                        st_nxt.gmii.er = 1'b1;
                    end
                    else if (isCtl(dec, `K_ERRP))
                    begin
                        st_nxt.gmii.dv = 1'b1;
                        st_nxt.gmii.er = 1'b1;
                    end
                    else
                    begin
                        st_nxt.gmii.dv = 1'b1;
                        st_nxt.gmii.data = dec.data;
                    end
                end
                pcs_rx_pkg::RX_END:
                begin
                    // /R/ groups after /T/ stay in the end state
                    if (!isCtl(dec, `K_CARR))
                    begin
                        st_nxt.rx = pcs_rx_pkg::RX_IDLE;
                    end
                end
                default:
                begin
                    st_nxt.rx = pcs_rx_pkg::RX_IDLE;
                end
            endcase
        end

        // status and indicators, all from the next sync state
        st_nxt.link = (st_nxt.sync == pcs_rx_pkg::SYNC_OK);
        st_nxt.panel = st_nxt.link && !autoNegEna;
        st_nxt.crs = st_nxt.link && (rxActive || txActive);
        st_nxt.col = st_nxt.link && sgmiiMode && halfDuplex && rxActive && txActive;
    end

    // **********************************************************************
    // state register and outputs
    // **********************************************************************

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // one flop feeds both the mii pin and the indicator
    assign gmiiRx = st_r.gmii;
    assign miiRxCrs = st_r.crs;
    assign ledCrs = st_r.crs;
    assign miiRxCol = st_r.col;
    assign ledCol = st_r.col;
    assign ledLink = st_r.link;
    assign ledPanelLink = st_r.panel;

    // **********************************************************************
    // assertions
    // **********************************************************************

    property p_sync_acquire;
        @(posedge mclk) disable iff (reset)
        st_r.sync == pcs_rx_pkg::SYNC_ACQ && st_r.commaCnt == 2'h2 && isComma && !bad
            && !realign |=> ledLink;
    endproperty
    a_sync_acquire: assert property (p_sync_acquire)
        else $error("link not acquired after third clean comma");

    property p_err_up;
        @(posedge mclk) disable iff (reset)
        !search && errIn && st_r.errCnt < 3'h3 |=> st_r.errCnt == $past(st_r.errCnt) + 3'h1;
    endproperty
    a_err_up: assert property (p_err_up)
        else $error("error count did not rise");

    property p_err_down;
        @(posedge mclk) disable iff (reset)
        !search && !errIn && dec.valid && st_r.goodCnt == 3'h3 && st_r.errCnt != 3'h0
            |=> st_r.errCnt == $past(st_r.errCnt) - 3'h1;
    endproperty
    a_err_down: assert property (p_err_down)
        else $error("error count did not fall after four good groups");

    property p_sync_lost;
        @(posedge mclk) disable iff (reset)
        !search && errIn && st_r.errCnt == 3'h3 |=> !ledLink && !st_r.locked;
    endproperty
    a_sync_lost: assert property (p_sync_lost)
        else $error("link kept after fourth error");

    property p_start;
        @(posedge mclk) disable iff (reset)
        !search && st_r.rx == pcs_rx_pkg::RX_IDLE && st_r.idleSeen && !bad
            && isCtl(dec, `K_SOF) |=> gmiiRx.dv && !gmiiRx.er && gmiiRx.data == `PREAMBLE;
    endproperty
    a_start: assert property (p_start)
        else $error("start symbol not replaced by preamble byte");

    property p_end;
        @(posedge mclk) disable iff (reset)
        !search && st_r.rx == pcs_rx_pkg::RX_FRAME && !bad && isCtl(dec, `K_EOF)
            |=> !gmiiRx.dv ##1 !gmiiRx.dv;
    endproperty
    a_end: assert property (p_end)
        else $error("frame not ended on terminate");

    property p_errprop;
        @(posedge mclk) disable iff (reset)
        !search && st_r.rx == pcs_rx_pkg::RX_FRAME && isCtl(dec, `K_ERRP)
            |=> gmiiRx.dv && gmiiRx.er;
    endproperty
    a_errprop: assert property (p_errprop)
        else $error("error propagation not reported");

    property p_false_carrier;
        @(posedge mclk) disable iff (reset)
        !search && st_r.rx == pcs_rx_pkg::RX_IDLE && bad
            |=> !gmiiRx.dv && gmiiRx.er && gmiiRx.data == `FALSE_CARR;
    endproperty
    a_false_carrier: assert property (p_false_carrier)
        else $error("wrong carrier not reported");

    property p_crs_link;
        @(posedge mclk) disable iff (reset)
        (miiRxCrs || miiRxCol) |-> ledLink && ledCrs == miiRxCrs && ledCol == miiRxCol;
    endproperty
    a_crs_link: assert property (p_crs_link)
        else $error("carrier or collision without link");

    property p_col_mode;
        @(posedge mclk) disable iff (reset)
        !(sgmiiMode && halfDuplex) |=> !miiRxCol && !ledCol;
    endproperty
    a_col_mode: assert property (p_col_mode)
        else $error("collision outside sgmii half duplex");

endmodule

/* File: pcs_rx_defines.svh */
// constants of the receive pcs: code patterns, control characters, sync counts
`ifndef PCS_RX_DEFINES_SVH
`define PCS_RX_DEFINES_SVH

// comma bits f,i,e..a of a code group, bit a arrives first
`define COMMA_NEG 7'h7c
`define COMMA_POS 7'h03

// k28 six-bit sub-blocks and the alternate 3b/4b sub-blocks
`define K28_NEG 6'h0f
`define K28_POS 6'h30
`define A7_NEG 4'h7
`define A7_POS 4'h8

// decoded control characters
`define K_COMMA1 8'h3c
`define K_COMMA5 8'hbc
`define K_COMMA7 8'hfc
`define K_SOF 8'hfb
`define K_EOF 8'hfd
`define K_CARR 8'hf7
`define K_ERRP 8'hfe

// bytes handed to the mac
`define PREAMBLE 8'h55
`define FALSE_CARR 8'h0e

// synchronization counts
`define SYNC_COMMAS 2'h3
`define ERR_LIMIT 3'h4
`define GOOD_RUN 3'h4

`endif

/* File: pcs_rx_pkg.sv */
// shared types of the receive pcs
package pcs_rx_pkg;

    // link synchronization states
    typedef enum logic [1:0] {SYNC_LOSS, SYNC_ACQ, SYNC_OK} syncState_t;

    // frame de-encapsulation states
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_END, RX_FALSE} rxState_t;

    // one decoded code group
    typedef struct packed {
        logic valid;
        logic isK;
        logic [7:0] data;
        logic codeErr;
        logic dispErr;
    } decChar_t;

    // gmii receive group towards the mac
    typedef struct packed {
        logic dv;
        logic er;
        logic [7:0] data;
    } gmiiRx_t;

    // decoder state
    typedef struct packed {
        logic rd;
        decChar_t out;
    } decState_t;

    // receive pcs state
    typedef struct packed {
        logic [9:0] prevWord;
        logic locked;
        logic [3:0] offset;
        logic misplaced;
        syncState_t sync;
        logic [1:0] commaCnt;
        logic [2:0] errCnt;
        logic [2:0] goodCnt;
        rxState_t rx;
        logic lastK285;
        logic idleSeen;
        gmiiRx_t gmii;
        logic crs;
        logic col;
        logic link;
        logic panel;
    } rxMain_t;

endpackage

/* File: pcs_dec_8b10b.sv */
// 8b/10b decoder with running disparity check, one cycle latency
`timescale 1ns/1ps
`include "pcs_rx_defines.svh"

module pcs_dec_8b10b (
    // clock and synchronous reset
    input wire logic mclk,
    input wire logic reset,
    // aligned code group, bit a in bit 0
    input wire logic [9:0] charIn,
    input wire logic charEn,
    // decoded character
    output pcs_rx_pkg::decChar_t decOut
);

    pcs_rx_pkg::decState_t st_r;
    pcs_rx_pkg::decState_t st_nxt;

    // 5b/6b, sub-block written abcdei; result is {ok, x}
    function automatic logic [5:0] dec6(input logic [5:0] s);
        case (s)
            6'h27, 6'h18: return 6'h20;
            6'h1d, 6'h22: return 6'h21;
            6'h2d, 6'h12: return 6'h22;
            6'h31: return 6'h23;
            6'h35, 6'h0a: return 6'h24;
            6'h29: return 6'h25;
            6'h19: return 6'h26;
            6'h38, 6'h07: return 6'h27;
            6'h39, 6'h06: return 6'h28;
            6'h25: return 6'h29;
            6'h15: return 6'h2a;
            6'h34: return 6'h2b;
            6'h0d: return 6'h2c;
            6'h2c: return 6'h2d;
            6'h1c: return 6'h2e;
            6'h17, 6'h28: return 6'h2f;
            6'h1b, 6'h24: return 6'h30;
            6'h23: return 6'h31;
            6'h13: return 6'h32;
            6'h32: return 6'h33;
            6'h0b: return 6'h34;
            6'h2a: return 6'h35;
            6'h1a: return 6'h36;
            6'h3a, 6'h05: return 6'h37;
            6'h33, 6'h0c: return 6'h38;
            6'h26: return 6'h39;
            6'h16: return 6'h3a;
            6'h36, 6'h09: return 6'h3b;
            6'h0e, `K28_NEG, `K28_POS: return 6'h3c;
            6'h2e, 6'h11: return 6'h3d;
            6'h1e, 6'h21: return 6'h3e;
            6'h2b, 6'h14: return 6'h3f;
            default: return 6'h00;
        endcase
    endfunction

    // 3b/4b, sub-block written fghj; result is {ok, y}
    function automatic logic [3:0] dec4(input logic [3:0] s);
        case (s)
            4'hb, 4'h4: return 4'h8;
            4'h9: return 4'h9;
            4'h5: return 4'ha;
            4'hc, 4'h3: return 4'hb;
            4'hd, 4'h2: return 4'hc;
            4'ha: return 4'hd;
            4'h6: return 4'he;
            4'he, 4'h1, `A7_NEG, `A7_POS: return 4'hf;
            default: return 4'h0;
        endcase
    endfunction

    // decode and disparity check; rd 1 means positive
    always_comb
    begin
        logic [5:0] s6;
        logic [3:0] s4;
        logic [5:0] r6;
        logic [3:0] r4;
        logic k28;
        logic kAlt;
        logic rdMid;
        int n6;
        int n4;
        s6 = {charIn[0], charIn[1], charIn[2], charIn[3], charIn[4], charIn[5]};
        s4 = {charIn[6], charIn[7], charIn[8], charIn[9]};
        k28 = (s6 == `K28_NEG) || (s6 == `K28_POS);
        kAlt = (s4 == `A7_NEG || s4 == `A7_POS)
            && (s6 == 6'h3a || s6 == 6'h05 || s6 == 6'h36 || s6 == 6'h09
            || s6 == 6'h2e || s6 == 6'h11 || s6 == 6'h1e || s6 == 6'h21);
        // k28 with positive sub-block inverts its tail
        r6 = dec6(s6);
        r4 = dec4((s6 == `K28_POS) ? ~s4 : s4);
        n6 = $countones(s6);
        n4 = $countones(s4);
        rdMid = (n6 == 4) ? 1'b1 : (n6 == 2) ? 1'b0 : st_r.rd;
        st_nxt = st_r;
        st_nxt.out.valid = charEn;
        st_nxt.out.isK = k28 || kAlt;
        st_nxt.out.data = {r4[2:0], r6[4:0]};
        st_nxt.out.codeErr = !r6[5] || !r4[3] || n6 < 2 || n6 > 4 || n4 < 1 || n4 > 3;
        st_nxt.out.dispErr = (n6 == 4 && st_r.rd) || (n6 == 2 && !st_r.rd)
            || (n4 == 3 && rdMid) || (n4 == 1 && !rdMid);
        if (charEn)
        begin
            st_nxt.rd = (n4 == 3) ? 1'b1 : (n4 == 1) ? 1'b0 : rdMid;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign decOut = st_r.out;

endmodule

/* File: serdes_model.sv */
// serdes model: idle pairs between queued code groups
`timescale 1ns/1ps

module serdes_model (
    // receive clock
    input wire logic mclk,
    // code group, bit a in bit 0
    output logic [9:0] tbiRxData
);
    // queued words, written in abcdeifghj order
    logic [9:0] q[$];
    logic phase = 1'b0;
    logic [9:0] w;

    // *****************************
    // stream
    // *****************************
    // idle pairs leave disparity negative at each pair edge, so queued frames fit in
    initial tbiRxData = 10'h000;
    always @(negedge mclk)
    begin
        if (q.size() > 0)
            w = q.pop_front();
        else
        begin
            w = phase ? 10'h245 : 10'h0fa;
            phase <= !phase;
        end
        for (int i = 0; i < 10; i++)
            tbiRxData[i] <= w[9 - i];
    end
endmodule

/* File: tb_top.sv */
// testbench of the receive pcs
`timescale 1ns/1ps

module tb_top;
    // code groups in abcdeifghj order
    localparam logic [9:0] K285 = 10'h0fa, D162 = 10'h245, SOF = 10'h368, DA = 10'h2aa;
    localparam logic [9:0] DB = 10'h155, EOF = 10'h2e8, RPT = 10'h3a8, ERRP = 10'h1e8;
    localparam logic [9:0] BAD = 10'h000;
    logic mclk = 1'b0, reset = 1'b1, sgmiiMode = 1'b1, autoNegEna = 1'b0;
    logic halfDuplex = 1'b1, txActive = 1'b0, miiRxCrs, miiRxCol;
    logic ledLink, ledPanelLink, ledCrs, ledCol;
    logic [9:0] tbiRxData;
    pcs_rx_pkg::gmiiRx_t gmiiRx;
    logic [7:0] rxBytes[$];
    int errors = 0, checked = 0, cycles = 0, erHits, erPos, fcHits, colHits, crsHits, drops;

    serdes_model PEER (.mclk(mclk), .tbiRxData(tbiRxData));
    pcs_rx_decode_sync DUT (.mclk(mclk), .reset(reset), .tbiRxData(tbiRxData),
        .sgmiiMode(sgmiiMode), .autoNegEna(autoNegEna), .halfDuplex(halfDuplex),
        .txActive(txActive), .gmiiRx(gmiiRx), .miiRxCrs(miiRxCrs), .miiRxCol(miiRxCol),
        .ledLink(ledLink), .ledPanelLink(ledPanelLink), .ledCrs(ledCrs), .ledCol(ledCol));

    // *****************************
    // clock, monitor, checks
    // *****************************
    initial forever #2 mclk = !mclk;

    // led copies are compared every cycle, so a lagging copy cannot hide;
    // sampled mid-cycle so every output has settled after its launching edge
    always @(negedge mclk)
    begin
        cycles++;
        check({ledCrs, ledCol}, {miiRxCrs, miiRxCol});
        if (gmiiRx.dv === 1'b1 && gmiiRx.er === 1'b1 && erHits++ == 0)
            erPos = rxBytes.size();
        if (gmiiRx.dv === 1'b1)
            rxBytes.push_back(gmiiRx.data);
        fcHits += (gmiiRx.dv === 1'b0 && gmiiRx.er === 1'b1 && gmiiRx.data === 8'h0e);
        colHits += (miiRxCol === 1'b1);
        crsHits += (miiRxCrs === 1'b1);
        drops += (ledLink === 1'b0);
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end

    // wide enough for several counters compared at once
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // queue groups only on an idle pair edge so disparity stays legal
    task automatic send(input logic [9:0] w[$]);
        {erHits, fcHits, colHits, crsHits, drops} = '0;
        rxBytes = {};
        @(posedge mclk);
        while (PEER.phase !== 1'b0)
            @(posedge mclk);
        foreach (w[i])
            PEER.q.push_back(w[i]);
        repeat (w.size() + 12) @(posedge mclk);
    endtask

    task automatic frame_test(input logic [9:0] w[$], input logic [7:0] exp[$], int n);
        send(w);
        check(rxBytes.size(), n);
        foreach (exp[i])
            check(rxBytes[i], exp[i]);
    endtask

    // *****************************
    // scenarios
    // *****************************
    task automatic t_sync();
        for (int i = 0; i < 200 && ledLink !== 1'b1; i++)
            @(negedge mclk);
        check(ledLink, 1'b1);
        check(ledPanelLink, 1'b1);
        @(negedge mclk) autoNegEna = 1'b1;
        repeat (3) @(posedge mclk);
        check(ledPanelLink, 1'b0);
        @(negedge mclk) autoNegEna = 1'b0;
        send({K285, D162, K285, D162});
        check({fcHits, crsHits, colHits}, 0);
    endtask

    task automatic t_frames();
        frame_test({K285, D162, SOF, DA, DB, EOF, RPT, RPT}, {8'h55, 8'hb5, 8'h4a}, 3);
        check({crsHits > 0, colHits, erHits}, {1'b1, 64'h0});
        @(negedge mclk) txActive = 1'b1;
        frame_test({K285, D162, SOF, DB, EOF, RPT}, {8'h55, 8'h4a}, 2);
        check(colHits > 0, 1'b1);
        @(negedge mclk) halfDuplex = 1'b0;
        frame_test({K285, D162, SOF, DB, EOF, RPT}, {8'h55, 8'h4a}, 2);
        check(colHits, 0);
        // 1000base-x at half duplex must stay free of collisions too
        @(negedge mclk) halfDuplex = 1'b1;
        sgmiiMode = 1'b0;
        frame_test({K285, D162, SOF, DB, EOF, RPT}, {8'h55, 8'h4a}, 2);
        check(colHits, 32'h0);
        check(ledPanelLink, 1'b1);
        @(negedge mclk) txActive = 1'b0;
        sgmiiMode = 1'b1;
    endtask

    task automatic t_errors();
        frame_test({K285, D162, SOF, DA, ERRP, DB, EOF, RPT}, {8'h55, 8'hb5}, 4);
        check({erHits, erPos}, {32'h1, 32'h2});
        send({K285, D162, SOF, DA, BAD, EOF, RPT});
        check({erHits > 0, erPos}, {1'b1, 32'h2});
        send({K285, D162, DA, DB});
        check({fcHits > 0, crsHits}, {1'b1, 32'h0});
    endtask

    // two bad groups per burst: without decrements the second burst would drop the link
    task automatic t_sync_loss();
        for (int i = 0; i < 3; i++)
        begin
            send({BAD, BAD});
            repeat (40) @(posedge mclk);
            check(drops, 0);
        end
        send({BAD, BAD, BAD, BAD, BAD, BAD, BAD, BAD});
        check(drops > 0, 1'b1);
        for (int i = 0; i < 200 && ledLink !== 1'b1; i++)
            @(negedge mclk);
        check(ledLink, 1'b1);
    endtask

    task automatic end_of_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        check({gmiiRx, miiRxCrs, miiRxCol, ledLink, ledPanelLink}, 0);
        repeat (4) @(posedge mclk);
        @(negedge mclk) reset = 1'b0;
        // outputs launched by the first two edges after release
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check({gmiiRx, ledLink, ledCrs, ledCol}, 0);
        t_sync();
        t_frames();
        t_errors();
        t_sync_loss();
        end_of_test();
    end
endmodule
